// ---- design/audio_sync_rate_ctrl.sv ----
// Frame sync, master request pacing, sample rate choice, error muting and gain smoothing
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Muted after reset until sync verified
// - Hunt for sync pattern or pulse
// - Verify frames muted; false sync rehunts
// - Muted frame count from CRC, free format
// - Unsynced requests use last selected rate
// - Default request rate 384 with source 0
// - Source 1 rate scales from sample clock
// - On lock adopt differing decoded rate
// - Slave select or stop halts requests
// - Resume at memorised master rate
// - Otherwise request speed stays unchanged
// - Crystal mode picks rate, default 44.1
// - Sample clocks change only at allowed events
// - Restore memorised master sample rate
// - Error flag, CRC fail, syntax mean errors
// - Header/alloc/select mute; scale factor reused
// - With CRC ignore flags for alloc, select
// - Force flag makes CRC present
// - Sub-band error indication for concealment
// - Gain takes effect within sample, smoothed
// - Index 127 zero gain, above reserved
//
// Our own choices: the register offsets and the strobed register port.
module audio_sync_rate_ctrl (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic [3:0]                regAddr,
	input  wire logic [31:0]               regWdata,
	input  wire logic                      regWr,
	input  wire logic                      regRd,
	output logic [31:0]                    regRdata,
	input  wire logic                      sample_rate_clock_in,
	input  wire logic                      sample_clock_source_sel,
	input  wire logic                      sample_clock_ratio_sel,
	input  wire logic                      master_input_error_flag,
	input  wire logic                      slave_input_error_flag,
	input  wire logic                      masterInputSel,
	input  wire logic                      stopDecode,
	input  wire logic                      dataPresent,
	input  wire logic                      syncHit,
	input  wire logic                      frameChecked,
	input  wire audio_sync_pkg::frame_info_t frameInfo,
	input  wire logic                      fieldErrStrobe,
	input  wire audio_sync_pkg::field_err_t  fieldErr,
	input  wire logic                      frameStart,
	output logic                           subbandMute,
	output logic                           basebandMute,
	output logic                           subbandErr,
	output logic                           reuseScaleFactor,
	output logic                           requestActive,
	output logic                           requestWord,
	output logic [8:0]                     requestRate,
	output audio_sync_pkg::fs_sel_t          sampleRateSel,
	output logic                           xtalTiming,
	output logic                           syncPulseMode,
	output audio_sync_pkg::gain_set_t        gainApplied
);
	import audio_sync_pkg::*;

	sync_state_t        state;
	logic [1:0]         mutedCnt;
	logic [1:0]         ctrlReg;
	logic [PIN_W-1:0]   pinMeta;
	logic [PIN_W-1:0]   pinSync;
	logic               fsClkDly;
	logic               prevMaster;
	logic               frameBad;
	logic [22:0]        wordAcc;
	logic [1:0]         gainIdx;
	logic [7:0]         gainTarget [4];
	logic [7:0]         gainNow    [4];

	// Synchronised pin views
	logic fsClkS, srcSelS, ratioSelS, mErrS, sErrS, masterS, stopS;
	assign {fsClkS, srcSelS, ratioSelS, mErrS, sErrS, masterS, stopS} = pinSync;

	logic crcOn, crcNow, crcHdr, needDone, lockEvent, lockedNext, pinErr, fieldBad, fsEdge;
	logic [1:0] needFrames;

	// Muted verification frames for a given header
	function automatic logic [1:0] muted_frames(input logic crc, input logic free);
		if (crc)
			muted_frames = free ? 2'h1 : 2'h0;
		else
			muted_frames = free ? 2'h2 : 2'h1;
	endfunction : muted_frames

	// One smoothing step toward the target index
	function automatic logic [7:0] step_toward(input logic [7:0] now, input logic [7:0] tgt);
		if (now < tgt)
			step_toward = now + 8'h01;
		else if (now > tgt)
			step_toward = now - 8'h01;
		else
			step_toward = now;
	endfunction : step_toward

	////////////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser for every pin input
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinMeta <= '0;
			pinSync <= '0;
			fsClkDly <= 1'b0;
		end else begin
			pinMeta <= {sample_rate_clock_in, sample_clock_source_sel, sample_clock_ratio_sel,
				master_input_error_flag, slave_input_error_flag, masterInputSel, stopDecode};
			pinSync <= pinMeta;
			fsClkDly <= fsClkS;
		end
	end

	assign fsEdge = fsClkS & ~fsClkDly;
	assign crcOn = frameInfo.hdrCrc | ctrlReg[CTRL_FORCE_CRC];
	assign needFrames = muted_frames(crcOn, frameInfo.freeFormat);
	assign needDone = (mutedCnt == needFrames);
	assign lockEvent = (state == ST_VERIFY) && frameChecked && frameInfo.syncOk && needDone;
	// Lock kept or gained at this edge; mutes follow the state with no lag
	assign lockedNext = !(stopS || (prevMaster != masterS))
		&& (((state == ST_LOCKED) && !(frameChecked && !frameInfo.syncOk)) || lockEvent);

	// Header protection held from the last checked frame; frame info is junk in between
	always_ff @(posedge mclk) begin
		if (!rst_n)
			crcHdr <= 1'b0;
		else if (frameChecked)
			crcHdr <= frameInfo.hdrCrc;
	end
	assign crcNow = crcHdr | ctrlReg[CTRL_FORCE_CRC];

	////////////////////////////////////////////////////////////////////////////////
	// Sync state machine; stop or an interface switch drops sync, a failed sync check rehunts
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			mutedCnt <= 2'h0;
			prevMaster <= 1'b0;
		end else begin
			prevMaster <= masterS;
			if (stopS || (prevMaster != masterS)) begin
				state <= ST_IDLE;
				mutedCnt <= 2'h0;
			end else begin
				case (state)
					ST_IDLE: begin
						if (dataPresent)
							state <= ST_HUNT;
					end
					ST_HUNT: begin
						if (syncHit) begin
							state <= ST_VERIFY;
							mutedCnt <= 2'h0;
						end
					end
					ST_VERIFY: begin
						if (frameChecked) begin
							if (!frameInfo.syncOk)
								state <= ST_HUNT;
							else if (needDone)
								state <= ST_LOCKED;
							else
								mutedCnt <= mutedCnt + 2'h1;
						end
					end
					ST_LOCKED: begin
						if (frameChecked && !frameInfo.syncOk)
							state <= ST_HUNT;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Error classification per field
	// three error sources
	assign pinErr = masterS ? mErrS : sErrS;
	// with CRC its result, not the flag, counts for allocation and select
	always_comb begin
		fieldBad = fieldErr.syntaxErr;
		case (fieldErr.field)
			FLD_ALLOC, FLD_SFSEL: fieldBad = fieldBad | (crcNow ? fieldErr.crcFail : pinErr);
			default:              fieldBad = fieldBad | pinErr | (crcNow & fieldErr.crcFail);
		endcase
	end

	// Frame error state, cleared at each frame start; an error in that cycle wins
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frameBad <= 1'b0;
			subbandErr <= 1'b0;
			reuseScaleFactor <= 1'b0;
		end else begin
			reuseScaleFactor <= 1'b0;
			if (frameStart) begin
				frameBad <= 1'b0;
				subbandErr <= 1'b0;
			end
			if (fieldErrStrobe && fieldBad) begin
				subbandErr <= 1'b1;
				case (fieldErr.field)
					FLD_HEADER, FLD_ALLOC, FLD_SFSEL: frameBad <= 1'b1;
					FLD_SCALE:                        reuseScaleFactor <= 1'b1;
					default:                          ;
				endcase
			end
		end
	end

	// mute until locked, also on bad frames
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			subbandMute <= 1'b1;
			basebandMute <= 1'b1;
		end else begin
			subbandMute <= !lockedNext || frameBad;
			basebandMute <= !lockedNext || frameBad;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Memorised master bit rate; survives slave use and stop
	// kept across switches
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			// default rate, scaled by the sample clock when source is 1
			requestRate <= RATE_DEFAULT;
		end else if (lockEvent && masterS && (frameInfo.rateKbps != requestRate)) begin
			requestRate <= frameInfo.rateKbps;
		end
	end

	// requests only on master input without stop
	always_ff @(posedge mclk) begin
		if (!rst_n)
			requestActive <= 1'b0;
		else
			requestActive <= masterS && !stopS;
	end

	// Word pacing by fractional accumulation; the sample clock path needs no divider
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wordAcc <= 23'h0;
			requestWord <= 1'b0;
		end else begin
			requestWord <= 1'b0;
			if (!requestActive) begin
				wordAcc <= 23'h0;
			end else if (!srcSelS) begin
				// pacing at the last selected rate
				if (wordAcc >= THRESH_XTAL) begin
					wordAcc <= wordAcc - THRESH_XTAL + 23'(requestRate);
					requestWord <= 1'b1;
				end else
					wordAcc <= wordAcc + 23'(requestRate);
			end else if (fsEdge) begin
				if (wordAcc >= (ratioSelS ? THRESH_FS384 : THRESH_FS256)) begin
					wordAcc <= wordAcc - (ratioSelS ? THRESH_FS384 : THRESH_FS256)
						+ 23'(requestRate * RATE_SCALE);
					requestWord <= 1'b1;
				end else
					wordAcc <= wordAcc + 23'(requestRate * RATE_SCALE);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample rate choice; crystal timing only for master input with source 0
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sampleRateSel <= FS_44K1;
			xtalTiming <= 1'b0;
		end else begin
			// memorised rate returns with crystal timing
			xtalTiming <= masterS && !srcSelS;
			if (lockEvent && masterS && !srcSelS)
				sampleRateSel <= frameInfo.fsCode;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes: control bits and the gain index sequence
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrlReg <= CTRL_RESET;
			syncPulseMode <= 1'b0;
		end else begin
			if (regWr && regAddr == OFS_CTRL)
				ctrlReg <= regWdata[1:0];
			syncPulseMode <= ctrlReg[CTRL_PULSE_SYNC];
		end
	end

	// Gains arrive in the fixed order; the slot counter wraps after the fourth
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gainIdx <= 2'h0;
			for (int i = 0; i < 4; i++)
				gainTarget[i] <= GAIN_RESET;
		end else if (regWr && regAddr == OFS_GAIN) begin
			gainIdx <= gainIdx + 2'h1;
			// reserved indices leave the gain alone
			if (!regWdata[GAIN_RESERVED])
				gainTarget[gainIdx] <= regWdata[7:0];
		end
	end

	// one index per cycle, far inside a sample period, avoids clicks
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++)
				gainNow[i] <= GAIN_RESET;
		end else begin
			for (int i = 0; i < 4; i++)
				gainNow[i] <= step_toward(gainNow[i], gainTarget[i]);
		end
	end

	assign gainApplied = {gainNow[0], gainNow[1], gainNow[2], gainNow[3]};

	// Read data one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			regRdata <= 32'h0;
		end else if (regRd) begin
			case (regAddr)
				OFS_CTRL:   regRdata <= {30'h0, ctrlReg};
				OFS_STATUS: regRdata <= {23'h0, gainIdx, xtalTiming, sampleRateSel,
					requestActive, basebandMute, state};
				OFS_RATE:   regRdata <= {23'h0, requestRate};
				default:    regRdata <= 32'h0;
			endcase
		end else begin
			regRdata <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_verified_lock;
		(state == ST_VERIFY) && frameChecked && frameInfo.syncOk && needDone;
	endsequence

	property p_mute_unlocked;
		(state != ST_LOCKED) && !$past(lockEvent) |-> subbandMute && basebandMute;
	endproperty
	a_mute_unlocked: assert property (p_mute_unlocked) else $error("audio not muted");

	property p_false_sync;
		(state == ST_VERIFY) && frameChecked && !frameInfo.syncOk && !stopS
			&& (prevMaster == masterS) |=> (state == ST_HUNT);
	endproperty
	a_false_sync: assert property (p_false_sync) else $error("false sync kept");

	property p_lock_then_unmute;
		s_verified_lock ##0 (!stopS && prevMaster == masterS && !frameBad && !frameStart)
			|=> (state == ST_LOCKED) ##0 !subbandMute;
	endproperty
	a_lock_then_unmute: assert property (p_lock_then_unmute) else $error("no lock");

	property p_adopt_rate;
		s_verified_lock ##0 masterS |=> requestRate == $past(frameInfo.rateKbps);
	endproperty
	a_adopt_rate: assert property (p_adopt_rate) else $error("rate not adopted");

	property p_stop_halts;
		stopS |=> !requestActive ##1 !requestWord;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("requests kept");

	property p_rate_stable;
		!lockEvent |=> $stable(requestRate);
	endproperty
	a_rate_stable: assert property (p_rate_stable) else $error("rate changed");

	property p_fs_stable;
		!(lockEvent && masterS && !srcSelS) |=> $stable(sampleRateSel);
	endproperty
	a_fs_stable: assert property (p_fs_stable) else $error("fs changed");

	property p_gain_settles;
		regWr && regAddr == OFS_GAIN && !regWdata[GAIN_RESERVED] && gainIdx == 2'h0
			##1 !(regWr && regAddr == OFS_GAIN) [*8]
			|-> ##[0:130] (gainNow[0] == gainTarget[0]);
	endproperty
	a_gain_settles: assert property (p_gain_settles) else $error("gain slow");

	property p_scale_reuse;
		fieldErrStrobe && fieldBad && fieldErr.field == FLD_SCALE |=> reuseScaleFactor;
	endproperty
	a_scale_reuse: assert property (p_scale_reuse) else $error("no reuse");
endmodule : audio_sync_rate_ctrl

// ---- design/audio_sync_pkg.sv ----
// Shared constants, enumerations and carriers of the sync and rate control block
package audio_sync_pkg;
	// Register offsets (byte addresses)
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_RATE   = 4'h8;
	localparam logic [3:0] OFS_GAIN   = 4'hC;
	// Control register fields and reset value
	localparam int         CTRL_FORCE_CRC  = 0;
	localparam int         CTRL_PULSE_SYNC = 1;
	localparam logic [1:0] CTRL_RESET      = 2'h0;
	// Status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_MUTE      = 2;
	localparam int STAT_REQ       = 3;
	localparam int STAT_FS_LSB    = 4;
	localparam int STAT_XTAL      = 6;
	localparam int STAT_GAIN_LSB  = 7;
	// Bit rates in kbit/s; the clock rate in kHz
	localparam logic [8:0]  RATE_DEFAULT  = 9'h180;
	localparam int          CLK_KHZ       = 200000;
	localparam int          WORD_BITS     = 16;
	// Word threshold on the master clock: rate added once per cycle
	localparam logic [22:0] THRESH_XTAL   = 23'(CLK_KHZ * WORD_BITS);
	// Sample clock path: rate x10 added per edge, 44.1 kHz assumed
	localparam int          RATE_SCALE    = 10;
	localparam int          FS_ASSUMED_HZ_DIV100 = 441;
	localparam logic [22:0] THRESH_FS256  = 23'(256 * FS_ASSUMED_HZ_DIV100 * WORD_BITS);
	localparam logic [22:0] THRESH_FS384  = 23'(384 * FS_ASSUMED_HZ_DIV100 * WORD_BITS);
	// Gain index limits
	localparam logic [7:0] GAIN_RESET    = 8'h00;
	localparam int         GAIN_RESERVED = 7;
	// Pin bundle width
	localparam int PIN_W = 7;

	typedef enum logic [1:0] {ST_IDLE, ST_HUNT, ST_VERIFY, ST_LOCKED} sync_state_t;
	typedef enum logic [1:0] {FS_44K1, FS_48K, FS_32K} fs_sel_t;
	typedef enum logic [2:0] {FLD_HEADER, FLD_ALLOC, FLD_SFSEL, FLD_SCALE, FLD_OTHER} field_t;

	// Frame check result from the bitstream parser
	typedef struct packed {
		logic       syncOk;
		logic       hdrCrc;
		logic       freeFormat;
		logic [8:0] rateKbps;
		fs_sel_t    fsCode;
	} frame_info_t;

	// Field error report from the parser
	typedef struct packed {
		field_t field;
		logic   crcFail;
		logic   syntaxErr;
	} field_err_t;

	typedef struct packed {
		logic [7:0] leftToLeft;
		logic [7:0] leftToRight;
		logic [7:0] rightToLeft;
		logic [7:0] rightToRight;
	} gain_set_t;
endpackage : audio_sync_pkg

// ---- sim/coded_source_model.sv ----
// Coded data source model: parser events and input error flags
module coded_source_model (
	input  wire logic                       mclk,
	output logic                            dataPresent,
	output logic                            syncHit,
	output logic                            frameChecked,
	output audio_sync_pkg::frame_info_t     frameInfo,
	output logic                            fieldErrStrobe,
	output audio_sync_pkg::field_err_t      fieldErr,
	output logic                            frameStart,
	output logic                            master_input_error_flag,
	output logic                            slave_input_error_flag
);
	import audio_sync_pkg::*;

	// Idle levels; released data lines never keep their last value
	initial begin
		dataPresent = 1'b0;
		syncHit = 1'b0;
		frameChecked = 1'b0;
		frameInfo = '0;
		fieldErrStrobe = 1'b0;
		fieldErr = '0;
		frameStart = 1'b0;
		master_input_error_flag = 1'b0;
		slave_input_error_flag = 1'b0;
	end

	task automatic startData();
		@(posedge mclk);
		dataPresent <= 1'b1;
	endtask : startData

	task automatic syncFound();
		@(posedge mclk);
		syncHit <= 1'b1;
		@(posedge mclk);
		syncHit <= 1'b0;
	endtask : syncFound

	task automatic frameDone(input logic ok, input logic crc, input logic free,
		input logic [8:0] rate, input fs_sel_t fs);
		@(posedge mclk);
		frameChecked <= 1'b1;
		frameInfo    <= '{ok, crc, free, rate, fs};
		@(posedge mclk);
		frameChecked <= 1'b0;
		frameInfo    <= frame_info_t'(~frameInfo); // Garbage once released
	endtask : frameDone

	task automatic fieldError(input field_t f, input logic crcBad, input logic syn);
		@(posedge mclk);
		fieldErrStrobe <= 1'b1;
		fieldErr       <= '{f, crcBad, syn};
		@(posedge mclk);
		fieldErrStrobe <= 1'b0;
		fieldErr       <= field_err_t'(~fieldErr);
	endtask : fieldError

	task automatic pulseFrameStart();
		@(posedge mclk);
		frameStart <= 1'b1;
		@(posedge mclk);
		frameStart <= 1'b0;
	endtask : pulseFrameStart

	task automatic setFlag(input logic v);
		@(posedge mclk);
		master_input_error_flag <= v;
	endtask : setFlag
endmodule : coded_source_model

// ---- sim/tb.sv ----
// Self-checking bench of the sync and rate control block
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import audio_sync_pkg::*;

	logic        mclk, rst_n, regWr, regRd, sample_rate_clock_in;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata, rdData;
	logic        sample_clock_source_sel, sample_clock_ratio_sel, masterInputSel, stopDecode;
	logic        master_input_error_flag, slave_input_error_flag;
	logic        dataPresent, syncHit, frameChecked, fieldErrStrobe, frameStart;
	frame_info_t frameInfo;
	field_err_t  fieldErr;
	logic        subbandMute, basebandMute, subbandErr, reuseScaleFactor;
	logic        requestActive, requestWord, xtalTiming;
	logic [8:0]  requestRate;
	fs_sel_t     sampleRateSel;
	gain_set_t   gainApplied;
	int          badCount, checksDone, cycles, gap;

	audio_sync_rate_ctrl dut (.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.sample_rate_clock_in, .sample_clock_source_sel, .sample_clock_ratio_sel,
		.master_input_error_flag, .slave_input_error_flag, .masterInputSel, .stopDecode,
		.dataPresent, .syncHit, .frameChecked, .frameInfo, .fieldErrStrobe, .fieldErr,
		.frameStart, .subbandMute, .basebandMute, .subbandErr, .reuseScaleFactor,
		.requestActive, .requestWord, .requestRate, .sampleRateSel, .xtalTiming,
		.syncPulseMode(), .gainApplied);
	coded_source_model src (.mclk, .dataPresent, .syncHit, .frameChecked, .frameInfo,
		.fieldErrStrobe, .fieldErr, .frameStart, .master_input_error_flag,
		.slave_input_error_flag);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Sample clock runs free, phase unrelated to mclk
	// fixed rate, no reset needed
	initial begin
		sample_rate_clock_in = 1'b0;
		#7.3;
		forever #40 sample_rate_clock_in = ~sample_rate_clock_in;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			badCount++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Cycles pass; sample settled values afterwards
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wrReg

	task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rdReg

	// Stop pulse forces the block back to its sync search
	task automatic dropSync();
		@(posedge mclk);
		stopDecode <= 1'b1;
		cyc(6);
		@(posedge mclk);
		stopDecode <= 1'b0;
		cyc(6);
	endtask : dropSync

	task automatic lockRun(input logic crc, input logic free, input int need,
		input logic [8:0] rate, input fs_sel_t fs);
		src.startData();
		cyc(3);
		src.syncFound();
		for (int i = 0; i < need; i++) begin
			src.frameDone(1'b1, crc, free, rate, fs);
			cyc(3);
			chk(32'(subbandMute), 32'h1);
		end
		src.frameDone(1'b1, crc, free, rate, fs);
		cyc(3);
		chk({subbandMute, basebandMute}, 32'h0);
		chk(32'(requestRate), 32'(rate));
	endtask : lockRun

	// Edge-sampled gap between two request pulses
	task automatic wordGap(output int g);
		int n;
		n = 0;
		@(posedge mclk);
		while (requestWord !== 1'b1 && n < 30000) begin
			@(posedge mclk);
			n++;
		end
		@(posedge mclk);
		g = 1;
		while (requestWord !== 1'b1 && g < 30000) begin
			@(posedge mclk);
			g++;
		end
	endtask : wordGap

	task automatic testReset();
		chk({subbandMute, basebandMute}, 32'h3);
		chk(32'(requestRate), 32'h180);
		chk(32'(sampleRateSel), 32'(FS_44K1));
		chk(gainApplied, 32'h0);
		rdReg(OFS_RATE, rdData);
		chk(rdData, 32'h180);
		rdReg(OFS_STATUS, rdData);
		chk({rdData[STAT_XTAL], rdData[STAT_MUTE]}, 32'h3);
	endtask : testReset

	// Every CRC and format combination, the need worked out per combination
	task automatic testLockTable();
		logic crc;
		logic free;
		for (int i = 0; i < 4; i++) begin
			crc  = i[1];
			free = i[0];
			dropSync();
			lockRun(crc, free, crc ? int'(free) : 1 + int'(free), 9'h0A0 + 9'(i * 32), FS_44K1);
		end
		dropSync();
		wrReg(OFS_CTRL, 32'h1);
		lockRun(1'b0, 1'b0, 0, 9'h100, FS_44K1);
		wrReg(OFS_CTRL, 32'h0);
	endtask : testLockTable

	task automatic testFalseSync();
		dropSync();
		src.startData();
		cyc(3);
		src.syncFound();
		src.frameDone(1'b0, 1'b0, 1'b0, 9'h040, FS_32K);
		cyc(3);
		rdReg(OFS_STATUS, rdData);
		chk({rdData[STAT_MUTE], rdData[STAT_STATE_LSB +: 2]}, {29'h0, 1'b1, ST_HUNT});
		chk(32'(requestRate), 32'h100);
		chk(32'(sampleRateSel), 32'(FS_44K1));
	endtask : testFalseSync

	task automatic testStopResume();
		@(posedge mclk);
		stopDecode <= 1'b1;
		cyc(6);
		chk({requestActive, requestRate}, 32'h100);
		@(posedge mclk);
		stopDecode <= 1'b0;
		cyc(6);
		chk(32'(requestActive), 32'h1);
		wordGap(gap);
		chk(32'(gap), 32'h30D4);
	endtask : testStopResume

	task automatic testSlave();
		dropSync();
		lockRun(1'b1, 1'b0, 0, 9'h0C0, FS_48K);
		chk(32'(sampleRateSel), 32'(FS_48K));
		@(posedge mclk);
		masterInputSel <= 1'b0;
		cyc(6);
		chk({requestActive, xtalTiming}, 32'h0);
		@(posedge mclk);
		masterInputSel <= 1'b1;
		cyc(6);
		chk({xtalTiming, sampleRateSel}, {29'h0, 1'b1, FS_48K});
		chk(32'(requestRate), 32'h0C0);
	endtask : testSlave

	task automatic testErrors();
		int n;
		n = 0;
		dropSync();
		lockRun(1'b0, 1'b0, 1, 9'h100, FS_44K1);
		src.fieldError(FLD_OTHER, 1'b0, 1'b1);
		cyc(3);
		chk({subbandErr, subbandMute}, 32'h2);
		src.pulseFrameStart();
		cyc(3);
		chk(32'(subbandErr), 32'h0);
		src.fieldError(FLD_SCALE, 1'b0, 1'b1);
		repeat (4) begin
			@(posedge mclk);
			n += int'(reuseScaleFactor);
		end
		chk(32'(n), 32'h1);
		chk(32'(subbandMute), 32'h0);
		wrReg(OFS_CTRL, 32'h1);
		src.setFlag(1'b1);
		cyc(4);
		src.fieldError(FLD_ALLOC, 1'b0, 1'b0);
		cyc(3);
		chk(32'(subbandMute), 32'h0);
		wrReg(OFS_CTRL, 32'h0);
		src.fieldError(FLD_ALLOC, 1'b0, 1'b0);
		cyc(3);
		chk(32'(subbandMute), 32'h1);
		src.setFlag(1'b0);
	endtask : testErrors

	task automatic testGains();
		logic [7:0] idx [4];
		idx = '{8'h10, 8'h20, 8'h7F, 8'h85};
		foreach (idx[i]) wrReg(OFS_GAIN, {24'h0, idx[i]});
		cyc(130);
		chk(gainApplied, 32'h10207F00);
		rdReg(OFS_STATUS, rdData);
		chk(32'(rdData[STAT_GAIN_LSB +: 2]), 32'h0);
		wrReg(OFS_GAIN, 32'h40);
		cyc(60);
		chk(gainApplied, 32'h40207F00);
		rdReg(OFS_GAIN, rdData);
		chk(rdData, 32'h0);
		rdReg(4'h2, rdData);
		chk(rdData, 32'h0);
		wrReg(OFS_RATE, 32'h1FF);
		rdReg(OFS_RATE, rdData);
		chk(rdData, 32'h100);
	endtask : testGains

	// source pin moves only under reset; 470 or 471 sample edges of 16 cycles
	task automatic testFsClock();
		@(posedge mclk);
		rst_n                   <= 1'b0;
		sample_clock_source_sel <= 1'b1;
		cyc(4);
		@(posedge mclk);
		rst_n <= 1'b1;
		cyc(6);
		chk({requestRate, xtalTiming, subbandMute}, {21'h0, 9'h180, 2'h1});
		wordGap(gap);
		chk(32'(gap >= 32'h1D60 && gap <= 32'h1D70), 32'h1);
	endtask : testFsClock

	// Hang guard, well above the expected run length
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			badCount++;
			summarize();
		end
	end

	initial begin
		rst_n = 1'b0;
		regAddr = 4'h0;
		regWdata = 32'h0;
		regWr = 1'b0;
		regRd = 1'b0;
		sample_clock_source_sel = 1'b0;
		sample_clock_ratio_sel = 1'b0;
		masterInputSel = 1'b1;
		stopDecode = 1'b0;
		badCount = 0;
		checksDone = 0;
		cycles = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		cyc(3);
		testReset();
		testLockTable();
		testFalseSync();
		testStopResume();
		testSlave();
		testErrors();
		testGains();
		testFsClock();
		summarize();
	end
endmodule : tb
